/* hdl/motion_ramp.sv */
`timescale 1ns/10ps
module motion_ramp #(
   parameter int RAMP_MAX    = ramp_pkg::RAMP_MAX_CYC,
   parameter int TEST_STEP   = ramp_pkg::TEST_STEP_CYC
) (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           ce,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [ramp_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic                           fwd_cmd,
   input  wire logic                           rev_cmd,
   input  wire logic                           speed_sel,
   input  wire logic                           mode_select_jumper,
   input  wire logic                           test_jumper,
   output logic      [ramp_pkg::VEL_W-1:0]     spool_mag,
   output logic                                spool_neg,
   output logic      [ramp_pkg::NUM_LEDS-1:0]  indicator
);
   import ramp_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_PINS-1:0] sync1;
      logic [NUM_PINS-1:0] sync2;
      logic [VEL_W-1:0]    fwd_high_velocity;
      logic [VEL_W-1:0]    fwd_low_velocity;
      logic [VEL_W-1:0]    rev_high_velocity;
      logic [VEL_W-1:0]    rev_low_velocity;
      logic [RATE_W-1:0]   accel_rate_setting;
      logic [RATE_W-1:0]   speed_step_decel_rate;
      logic [RATE_W-1:0]   stop_decel_rate;
      logic [31:0]         rdata;
      motion_t             st;
      logic [VEL_W-1:0]    mag;
      logic                neg;
      logic [31:0]         test_cnt;
      logic [NUM_LEDS-1:0] led;
      logic                test_done;
      logic                fault;
      logic                mode_slow;
   } ramp_state_t;

   ramp_state_t s;
   ramp_state_t next_s;

   logic [NUM_PINS-1:0] pins_raw;
   logic                run;
   logic                cmd_fwd;
   logic                cmd_rev;
   logic                sel_eff;
   logic [VEL_W-1:0]    hi_mag;
   logic [VEL_W-1:0]    lo_raw;
   logic [VEL_W-1:0]    lo_mag;
   logic [VEL_W-1:0]    tgt_mag;
   logic [VEL_W-1:0]    want;
   logic [VEL_W-1:0]    kick_val;
   logic                reversal;
   motion_t             next_st;
   logic                restart;
   logic [RATE_W-1:0]   period;
   logic                tick;
   logic                wr_en;
   logic                rd_setup;
   logic                addr_ok;

   localparam logic [RATE_W-1:0] RATE_LO = RATE_W'(RAMP_MIN_CYC);
   localparam logic [RATE_W-1:0] RATE_HI = RATE_W'(RAMP_MAX);

   function automatic logic [RATE_W-1:0] clamp_rate(input logic [31:0] v);
      if (v < 32'(RATE_LO))
         return RATE_LO;
      else if (v > 32'(RATE_HI))
         return RATE_HI;
      else
         return v[RATE_W-1:0];
   endfunction : clamp_rate

   // ------------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------------
   assign pins_raw = {test_jumper, mode_select_jumper, speed_sel,
                      rev_cmd, fwd_cmd};
   assign run      = ce && s.test_done && !s.fault;

   assign cmd_fwd  = s.sync2[PIN_FWD] && !s.sync2[PIN_REV];
   assign cmd_rev  = s.sync2[PIN_REV] && !s.sync2[PIN_FWD];
   assign sel_eff  = s.mode_slow || s.sync2[PIN_SEL];
   assign hi_mag   = cmd_rev ? s.rev_high_velocity : s.fwd_high_velocity;
   assign lo_raw   = cmd_rev ? s.rev_low_velocity : s.fwd_low_velocity;
   assign lo_mag   = (lo_raw > hi_mag) ? hi_mag : lo_raw;
   // high target on select or in slow mode; low target otherwise, clamped to high
   assign tgt_mag  = (cmd_fwd || cmd_rev) ? (sel_eff ? hi_mag : lo_mag)
                                          : '0;
   // a reversal must pass through zero first, at the stop rate (step rate in slow mode)
   assign reversal = (s.mag != '0) && (cmd_fwd || cmd_rev)
                     && (s.neg != cmd_rev);
   assign want     = reversal ? '0 : tgt_mag;
   assign kick_val = (want < KICK_MAG) ? want : KICK_MAG;

   // ------------------------------------------------------------------
   // motion sequencing
   // ------------------------------------------------------------------
   always_comb
   begin
      next_st = s.st;
      if (run)
      begin
         if (s.mag < want)
            next_st = ST_ACCEL;
         else if (s.mag > want)
            // stop state when target is zero (command gone or reversal); step state otherwise
            next_st = (want == '0) ? ST_STOP : ST_STEP;
         else
            next_st = (s.mag == '0) ? ST_IDLE : ST_HOLD;
      end
   end

   assign restart = (next_st != s.st);

   always_comb
   begin
      case (s.st)
         ST_ACCEL: period = s.accel_rate_setting;
         ST_STEP:  period = s.speed_step_decel_rate;
         ST_STOP:  period = s.mode_slow ? s.speed_step_decel_rate
                                        : s.stop_decel_rate;
         default:  period = s.stop_decel_rate;
      endcase
   end

   rate_tick #(
      .RATE_W (RATE_W)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .restart (restart),
      .period  (period),
      .tick    (tick)
   );

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign addr_ok  = (paddr[1:0] == 2'h0) && (paddr <= ADDR_STATUS);
   // zero wait state: read data is latched in the setup cycle
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !addr_ok;
   assign prdata   = s.rdata;

   assign spool_mag = s.mag;
   assign spool_neg = s.neg;
   assign indicator = s.led;

   always_comb
   begin
      next_s = s;
      if (ce)
      begin
         next_s.sync1 = pins_raw;
         next_s.sync2 = s.sync1;

         if (wr_en)
         begin
            if (paddr == ADDR_FWD_HI)
               next_s.fwd_high_velocity = pwdata[VEL_W-1:0];
            else if (paddr == ADDR_FWD_LO)
               next_s.fwd_low_velocity = pwdata[VEL_W-1:0];
            else if (paddr == ADDR_REV_HI)
               next_s.rev_high_velocity = pwdata[VEL_W-1:0];
            else if (paddr == ADDR_REV_LO)
               next_s.rev_low_velocity = pwdata[VEL_W-1:0];
            else if (paddr == ADDR_ACCEL)
               next_s.accel_rate_setting = clamp_rate(pwdata);
            else if (paddr == ADDR_STEP_DEC)
               next_s.speed_step_decel_rate = clamp_rate(pwdata);
            else if (paddr == ADDR_STOP_DEC)
               next_s.stop_decel_rate = clamp_rate(pwdata);
         end

         if (rd_setup)
         begin
            next_s.rdata = '0;
            if (paddr == ADDR_FWD_HI)
               next_s.rdata[VEL_W-1:0] = s.fwd_high_velocity;
            else if (paddr == ADDR_FWD_LO)
               next_s.rdata[VEL_W-1:0] = s.fwd_low_velocity;
            else if (paddr == ADDR_REV_HI)
               next_s.rdata[VEL_W-1:0] = s.rev_high_velocity;
            else if (paddr == ADDR_REV_LO)
               next_s.rdata[VEL_W-1:0] = s.rev_low_velocity;
            else if (paddr == ADDR_ACCEL)
               next_s.rdata[RATE_W-1:0] = s.accel_rate_setting;
            else if (paddr == ADDR_STEP_DEC)
               next_s.rdata[RATE_W-1:0] = s.speed_step_decel_rate;
            else if (paddr == ADDR_STOP_DEC)
               next_s.rdata[RATE_W-1:0] = s.stop_decel_rate;
            else if (paddr == ADDR_STATUS)
            begin
               next_s.rdata[STS_DONE]  = s.test_done;
               next_s.rdata[STS_FAULT] = s.fault;
               next_s.rdata[STS_NEG]   = s.neg;
               next_s.rdata[STS_SLOW]  = s.mode_slow;
               next_s.rdata[STS_STATE +: ST_W]  = s.st;
               next_s.rdata[STS_MAG +: VEL_W]   = s.mag;
            end
         end

         if (s.st == ST_TEST)
         begin
            if (s.test_cnt == 32'(TEST_STEP - 1))
            begin
               next_s.test_cnt = '0;
               if (s.led[NUM_LEDS-1])
               begin
                  next_s.test_done = 1'b1;
                  // strap caught at end of test, not under reset
                  next_s.mode_slow = s.sync2[PIN_MODE];
                  // jumper or live inputs at power up
                  if (s.sync2[PIN_TEST] || s.sync2[PIN_FWD]
                      || s.sync2[PIN_REV] || s.sync2[PIN_SEL])
                  begin
                     next_s.fault = 1'b1;
                     next_s.st    = ST_FAULT;
                     next_s.led   = '1;
                  end
                  else
                  begin
                     next_s.st  = ST_IDLE;
                     next_s.led = '0;
                  end
               end
               else
                  next_s.led = s.led << 1;
            end
            else
               next_s.test_cnt = s.test_cnt + 32'h0000_0001;
         end
         else if (run)
         begin
            next_s.st = next_st;
            if ((s.mag == '0) && (want != '0))
            begin
               next_s.mag = kick_val;
               next_s.neg = cmd_rev;
            end
            // low to high uses accel rate
            else if ((s.mag < want) && tick)
               next_s.mag = s.mag + 1'b1;
            else if ((s.mag > want) && tick)
               next_s.mag = s.mag - 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s                       <= '0;
         s.fwd_high_velocity     <= VEL_RESET;
         s.fwd_low_velocity      <= VEL_RESET;
         s.rev_high_velocity     <= VEL_RESET;
         s.rev_low_velocity      <= VEL_RESET;
         s.accel_rate_setting    <= ACCEL_RESET;
         s.speed_step_decel_rate <= STEP_RESET;
         s.stop_decel_rate       <= STOP_RESET;
         s.st                    <= ST_TEST;
         s.led                   <= NUM_LEDS'(1);
      end
      else
         s <= next_s;
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_rest_start;
      run && (s.mag == '0) && (want != '0);
   endsequence
   sequence s_kicked;
      (s.mag == $past(kick_val)) && (s.st == ST_ACCEL);
   endsequence
   a_rate_in_range: assert property (
      (s.accel_rate_setting >= RATE_LO) && (s.accel_rate_setting <= RATE_HI)
      && (s.stop_decel_rate >= RATE_LO) && (s.stop_decel_rate <= RATE_HI))
      else $error("rate setting outside ramp range");
   a_accel_period: assert property (
      (s.st == ST_ACCEL) |-> (period == s.accel_rate_setting))
      else $error("accel phase not using accel rate");
   a_high_target: assert property (
      (run && cmd_fwd && !reversal && s.sync2[PIN_SEL])
      |-> (want == s.fwd_high_velocity))
      else $error("forward high target wrong");
   a_step_decel: assert property (
      (run && (s.mag > want) && (want != '0) && !restart)
      |-> (period == s.speed_step_decel_rate))
      else $error("speed step decel not using step rate");
   a_stop_on_drop: assert property (
      (run && !cmd_fwd && !cmd_rev && (s.mag > 12'h001))
      |=> (s.st == ST_STOP))
      else $error("no stop ramp after command removed");
   a_low_clamp: assert property (
      lo_mag <= hi_mag)
      else $error("low setpoint above high setpoint");
   a_kick_start: assert property (
      s_rest_start |=> s_kicked)
      else $error("start from rest offset wrong");
   a_no_step_idle: assert property (
      (run && !tick && (s.mag != '0)) |=> (s.mag == $past(s.mag)))
      else $error("output moved without a rate tick");
   a_fault_stops: assert property (
      s.fault |-> (s.mag == '0) && (s.led == '1))
      else $error("fault without stop and indicators");
   a_test_clears: assert property (
      ($rose(s.test_done) && !s.fault) |-> (s.led == '0) ##1 (s.led == '0))
      else $error("indicators not cleared after test");
   a_both_cmds: assert property (
      (run && s.sync2[PIN_FWD] && s.sync2[PIN_REV]) |-> (want == '0))
      else $error("conflicting commands not treated as stop");
endmodule : motion_ramp

/* common/ramp_pkg.sv */
package ramp_pkg;

   // ------------------------------------------------------------------
   // clock and scale
   // ------------------------------------------------------------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int CLK_PER_MS    = CLK_HZ / 1000;
   localparam int VEL_W         = 12;
   localparam int RATE_W        = 16;
   localparam int FULL_SCALE    = 4095;
   localparam int FULL_SCALE_MV = 5000;

   // ------------------------------------------------------------------
   // ramp timing
   // ------------------------------------------------------------------
   localparam int RAMP_MIN_MS    = 25;
   localparam int RAMP_MAX_MS    = 15000;
   localparam int LEGACY_STOP_MS = 1000;
   localparam int TEST_STEP_MS   = 250;
   // cycles per output step; least time rounds up, longest rounds down
   localparam int RAMP_MIN_CYC =
      (RAMP_MIN_MS * CLK_PER_MS + FULL_SCALE - 1) / FULL_SCALE;
   localparam int RAMP_MAX_CYC = (RAMP_MAX_MS * CLK_PER_MS) / FULL_SCALE;
   localparam int LEGACY_STOP_CYC =
      (LEGACY_STOP_MS * CLK_PER_MS) / FULL_SCALE;
   localparam int TEST_STEP_CYC = TEST_STEP_MS * CLK_PER_MS;
   // start-from-rest offset of 1.875 units of a 5-unit full scale
   localparam int KICK_MV = 1875;
   localparam logic [VEL_W-1:0] KICK_MAG =
      VEL_W'((KICK_MV * FULL_SCALE) / FULL_SCALE_MV);

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_FWD_HI   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_FWD_LO   = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_REV_HI   = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_REV_LO   = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_ACCEL    = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_STEP_DEC = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_STOP_DEC = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h1c;

   localparam logic [VEL_W-1:0]  VEL_RESET   = 12'h000;
   localparam logic [RATE_W-1:0] ACCEL_RESET = RATE_W'(LEGACY_STOP_CYC);
   localparam logic [RATE_W-1:0] STEP_RESET  = RATE_W'(LEGACY_STOP_CYC);
   localparam logic [RATE_W-1:0] STOP_RESET  = RATE_W'(LEGACY_STOP_CYC);

   // status fields
   localparam int STS_DONE  = 0;
   localparam int STS_FAULT = 1;
   localparam int STS_NEG   = 2;
   localparam int STS_SLOW  = 3;
   localparam int STS_STATE = 8;
   localparam int STS_MAG   = 16;

   // pin vector positions
   localparam int NUM_PINS = 5;
   localparam int PIN_FWD  = 0;
   localparam int PIN_REV  = 1;
   localparam int PIN_SEL  = 2;
   localparam int PIN_MODE = 3;
   localparam int PIN_TEST = 4;

   localparam int NUM_LEDS = 4;
   localparam int ST_W     = 7;

   typedef enum logic [ST_W-1:0] {
      ST_IDLE  = 7'h01,
      ST_ACCEL = 7'h02,
      ST_HOLD  = 7'h04,
      ST_STEP  = 7'h08,
      ST_STOP  = 7'h10,
      ST_TEST  = 7'h20,
      ST_FAULT = 7'h40
   } motion_t;

endpackage : ramp_pkg

/* hdl/rate_tick.sv */
`timescale 1ns/10ps
module rate_tick #(
   parameter int RATE_W = ramp_pkg::RATE_W
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              restart,
   input  wire logic [RATE_W-1:0] period,
   output logic                   tick
);
   import ramp_pkg::*;

   typedef struct packed {
      logic [RATE_W-1:0] cnt;
   } tick_state_t;

   tick_state_t s;
   tick_state_t next_s;

   // period is never below the ramp minimum, so no zero case
   assign tick = ce && !restart && (s.cnt >= period - 1'b1);

   always_comb
   begin
      next_s = s;
      if (ce)
      begin
         if (restart || tick)
            next_s.cnt = '0;
         else
            next_s.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

endmodule : rate_tick

/* tb/machine_ctl.sv */
`timescale 1ns/10ps
module machine_ctl (
   input  wire logic pclk,
   output logic      fwd_cmd,
   output logic      rev_cmd,
   output logic      speed_sel,
   output logic      mode_select_jumper,
   output logic      test_jumper
);
   // all inputs quiet at power up
   initial
   begin
      fwd_cmd            = 1'b0;
      rev_cmd            = 1'b0;
      speed_sel          = 1'b0;
      mode_select_jumper = 1'b0;
      test_jumper        = 1'b0;
   end

   task automatic drive(input logic f, input logic r, input logic s);
      @(posedge pclk);
      fwd_cmd   <= f;
      rev_cmd   <= r;
      speed_sel <= s;
   endtask : drive

   // jumpers moved only around a reset
   task automatic jumpers(input logic m, input logic t);
      mode_select_jumper <= m;
      test_jumper        <= t;
   endtask : jumpers
endmodule : machine_ctl

/* tb/tb_two_speed_motion_profile_ramp.sv */
`timescale 1ns/10ps
module tb_two_speed_motion_profile_ramp;
   import ramp_pkg::*;
   logic                pclk;
   logic                presetn;
   logic                ce;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [7:0]          paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic                fwd_cmd;
   logic                rev_cmd;
   logic                speed_sel;
   logic                mode_select_jumper;
   logic                test_jumper;
   logic [VEL_W-1:0]    spool_mag;
   logic                spool_neg;
   logic [NUM_LEDS-1:0] indicator;
   logic [31:0]         rd;
   logic                er;
   int                  mismatches;
   int                  n_tests;

   machine_ctl ctl (
      .pclk(pclk), .fwd_cmd(fwd_cmd), .rev_cmd(rev_cmd),
      .speed_sel(speed_sel), .mode_select_jumper(mode_select_jumper),
      .test_jumper(test_jumper));

   // short self test keeps each reset cheap
   motion_ramp #(.TEST_STEP(4)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fwd_cmd(fwd_cmd), .rev_cmd(rev_cmd),
      .speed_sel(speed_sel), .mode_select_jumper(mode_select_jumper),
      .test_jumper(test_jumper), .spool_mag(spool_mag),
      .spool_neg(spool_neg), .indicator(indicator));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
         mismatches++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // waits for the spool to settle and judges how long it took
   task automatic ramp_to(input logic [11:0] t, input logic neg,
                          input int lo, input int hi);
      int n;
      n = 0;
      while (spool_mag !== t && n < 20000)
      begin
         @(negedge pclk);
         n++;
      end
      n_tests++;
      if (n < lo || n > hi || (t != 12'h000 && spool_neg !== neg))
      begin
         $display("BAD t=%0t mag %h exp %h n %0d", $time, spool_mag, t, n);
         mismatches++;
      end
   endtask : ramp_to

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   task automatic setup();
      apb(1'b1, ADDR_FWD_HI, 32'h00000028);
      apb(1'b1, ADDR_FWD_LO, 32'h0000001e);
      apb(1'b1, ADDR_REV_HI, 32'h00000032);
      apb(1'b1, ADDR_REV_LO, 32'h00000014);
      apb(1'b1, ADDR_ACCEL, 32'h00000050);
      apb(1'b1, ADDR_STEP_DEC, 32'h00000064);
      apb(1'b1, ADDR_STOP_DEC, 32'h0000003e);
   endtask : setup

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_defaults();
      chk(indicator, 32'h1);
      apb(1'b0, ADDR_STOP_DEC, 32'h0);
      chk(rd, 32'h0000098a);
      apb(1'b0, ADDR_ACCEL, 32'h0);
      chk(rd, 32'h0000098a);
      apb(1'b1, ADDR_ACCEL, 32'h00000001);
      apb(1'b0, ADDR_ACCEL, 32'h0);
      chk(rd, 32'h0000003e);
      apb(1'b1, ADDR_STEP_DEC, 32'h0000ffff);
      apb(1'b0, ADDR_STEP_DEC, 32'h0);
      chk(rd, 32'h00008f16);
      apb(1'b0, 8'h20, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      repeat (40) @(posedge pclk);
      chk(indicator, 32'h0);
   endtask : t_defaults

   task automatic t_fwd();
      // frozen clock enable must hold the spool at rest
      ce <= 1'b0;
      ctl.drive(1'b1, 1'b0, 1'b1);
      repeat (20) @(negedge pclk);
      chk(spool_mag, 32'h0);
      @(posedge pclk);
      ce <= 1'b1;
      ramp_to(12'h028, 1'b0, 0, 8);
      ctl.drive(1'b1, 1'b0, 1'b0);
      ramp_to(12'h01e, 1'b0, 1000, 1010);
      ctl.drive(1'b1, 1'b0, 1'b1);
      ramp_to(12'h028, 1'b0, 800, 810);
      ctl.drive(1'b0, 1'b0, 1'b1);
      ramp_to(12'h000, 1'b0, 2480, 2490);
   endtask : t_fwd

   task automatic t_rev();
      ctl.drive(1'b0, 1'b1, 1'b1);
      ramp_to(12'h032, 1'b1, 0, 8);
      ctl.drive(1'b0, 1'b1, 1'b0);
      ramp_to(12'h014, 1'b1, 3000, 3010);
      ctl.drive(1'b0, 1'b0, 1'b0);
      ramp_to(12'h000, 1'b0, 1240, 1250);
   endtask : t_rev

   task automatic t_low_start();
      ctl.drive(1'b1, 1'b0, 1'b0);
      ramp_to(12'h01e, 1'b0, 0, 8);
      ctl.drive(1'b1, 1'b1, 1'b0);
      ramp_to(12'h000, 1'b0, 1860, 1870);
      ctl.drive(1'b0, 1'b0, 1'b0);
   endtask : t_low_start

   task automatic t_clamp();
      apb(1'b1, ADDR_FWD_LO, 32'h0000003c);
      ctl.drive(1'b1, 1'b0, 1'b0);
      ramp_to(12'h028, 1'b0, 0, 8);
      repeat (20) @(negedge pclk);
      chk(spool_mag, 32'h28);
      ctl.drive(1'b0, 1'b0, 1'b0);
      ramp_to(12'h000, 1'b0, 2480, 2490);
   endtask : t_clamp

   task automatic t_jumper(input logic m, input logic t);
      @(posedge pclk);
      ctl.jumpers(m, t);
      do_reset();
      repeat (40) @(posedge pclk);
      setup();
      if (t)
      begin
         chk(indicator, 32'hf);
         ctl.drive(1'b1, 1'b0, 1'b1);
         repeat (20) @(negedge pclk);
         chk(spool_mag, 32'h0);
         ctl.drive(1'b0, 1'b0, 1'b0);
      end
      else
      begin
         chk(indicator, 32'h0);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk(rd[STS_SLOW], 32'h1);
         ctl.drive(1'b1, 1'b0, 1'b0);
         ramp_to(12'h028, 1'b0, 0, 8);
         ctl.drive(1'b0, 1'b0, 1'b0);
         ramp_to(12'h000, 1'b0, 4000, 4010);
      end
   endtask : t_jumper

   initial
   begin
      repeat (60000) @(posedge pclk);
      mismatches++;
      stop_test();
   end

   initial
   begin
      mismatches = 0;
      n_tests    = 0;
      presetn    = 1'b0;
      ce         = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 8'h00;
      pwdata     = 32'h0;
      do_reset();
      t_defaults();
      setup();
      t_fwd();
      t_rev();
      t_low_start();
      t_clamp();
      t_jumper(1'b0, 1'b1);
      t_jumper(1'b1, 1'b0);
      stop_test();
   end
endmodule : tb_two_speed_motion_profile_ramp
